/* include/ihw_pkg.sv */
// Package with constants and carrier types for the interrupt, halt and watchdog unit
package ihw_pkg;
   // -----------------------------------------------------------------
   // Register offsets (nibble-wide special function registers)
   // -----------------------------------------------------------------
   localparam logic [4:0] FLAGS_AND_IRQ_STATUS_ADDR = 5'h00;
   localparam logic [4:0] AUDIO_PWM_CONTROL_ADDR = 5'h09;
   localparam logic [4:0] ROM_DATA_HIGH_AND_WDT_CLEAR_ADDR = 5'h1D;
   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int ZERO_FLAG_BIT = 0;
   localparam int CARRY_FLAG_BIT = 1;
   localparam int PWM_REQUEST_FLAG_BIT = 2;
   localparam int PWM_OUTPUT_ENABLE_BIT = 0;
   localparam int IRQ_ENABLE_FIELD_BIT = 1;
   // -----------------------------------------------------------------
   // Vector addresses
   // -----------------------------------------------------------------
   localparam logic [11:0] RESET_VECTOR = 12'h000;
   localparam logic [11:0] WAKEUP_VECTOR = 12'h004;
   localparam logic [11:0] IRQ_VECTOR = 12'h008;
   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam longint CLK_HZ = 25000000;
   localparam longint IRQ_RATE_HZ = 32768;
   localparam longint STABLE_TIME_NS = 352000;
   localparam longint WDT_TIMEOUT_MS = 128;
   localparam longint NS_PER_S = 1000000000;
   // Longest-rate divider rounds down, least stabilisation time rounds up
   localparam longint IRQ_DIV_CYCLES = CLK_HZ / IRQ_RATE_HZ;
   localparam longint STABLE_CYCLES = (STABLE_TIME_NS * CLK_HZ + NS_PER_S - 1) / NS_PER_S;
   localparam longint WDT_CYCLES = (CLK_HZ / 1000) * WDT_TIMEOUT_MS;
   localparam logic [3:0] NIBBLE_ZERO = 4'h0;
   localparam logic [1:0] PWM_CTRL_RESET = 2'h0;

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      IHW_RUN = 2'b00,
      IHW_HALT = 2'b01,
      IHW_STABLE = 2'b10
   } ihw_mode_type;

   // Context saved on entry and restored on return
   typedef struct packed {
      logic [11:0] pc;
      logic [3:0] page_data_high_pointer;
      logic [1:0] memory_page_select;
      logic carry_flag;
      logic zero_flag;
   } ihw_context_type;

   // Register write strobe with address and nibble
   typedef struct packed {
      logic wr;
      logic [4:0] addr;
      logic [3:0] data;
   } ihw_reg_write_type;
endpackage

/* rtl/ihw_unit.sv */
// Interrupt entry and return, halt and wakeup sequencing, and watchdog supervision
`timescale 1ns/1ps
`default_nettype none

module ihw_unit #(
   parameter int PINS = 4,
   parameter longint STABLE_COUNT = ihw_pkg::STABLE_CYCLES,
   parameter longint WDT_COUNT = ihw_pkg::WDT_CYCLES,
   parameter longint IRQ_DIV = ihw_pkg::IRQ_DIV_CYCLES
) (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Chip reset request from power-on or low-voltage sources
   input wire logic chip_reset_req_in,
   // Core side
   input wire logic [11:0] next_pc_in,
   input wire ihw_pkg::ihw_context_type core_context_in,
   input wire logic instr_done_in,
   input wire logic return_from_irq_in,
   input wire logic halt_instr_in,
   input wire ihw_pkg::ihw_reg_write_type reg_write_in,
   input wire logic [4:0] reg_read_addr_in,
   // Options and port pins
   input wire logic wdt_option_enable_in,
   input wire logic [PINS-1:0] wakeup_option_enable_in,
   input wire logic [PINS-1:0] port_a_pins_in,
   // Outputs
   output logic pc_load_out,
   output logic [11:0] pc_load_value_out,
   output ihw_pkg::ihw_context_type restore_context_out,
   output logic restore_valid_out,
   output logic core_clock_run_out,
   output logic [3:0] reg_read_data_out,
   output logic global_irq_enable_out,
   output logic pwm_output_enable_out,
   output logic pwm_request_flag_out,
   output logic watchdog_reset_out
);
   import ihw_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   ihw_mode_type mode_q;
   ihw_context_type saved_q;
   logic global_irq_enable_q;
   logic pwm_output_enable_q;
   logic pwm_request_flag_q;
   logic [3:0] rom_data_high_q;
   logic [31:0] pwm_div_q;
   logic [31:0] stable_q;
   logic [31:0] wdt_q;
   logic [PINS-1:0] sync1_q;
   logic [PINS-1:0] sync2_q;
   logic [PINS-1:0] sync3_q;
   logic in_service_q;
   logic pwm_cycle_end;
   logic take_irq;
   logic wake_event;
   logic wdt_clear;
   logic wdt_overflow;
   logic halt_req;
   logic wr_status;
   logic wr_ctrl;
   logic wr_romh;
   logic [3:0] rd_d;

   localparam logic [31:0] PWM_DIV_LAST = 32'(IRQ_DIV - 1);
   localparam logic [31:0] STABLE_LAST = 32'(STABLE_COUNT - 1);
   localparam logic [31:0] WDT_LAST = 32'(WDT_COUNT - 1);
   localparam logic [31:0] COUNT_ZERO = 32'h0000_0000;
   localparam logic [31:0] COUNT_ONE = 32'h0000_0001;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   // Register write strobes
   assign wr_status = reg_write_in.wr && reg_write_in.addr == FLAGS_AND_IRQ_STATUS_ADDR;
   assign wr_ctrl = reg_write_in.wr && reg_write_in.addr == AUDIO_PWM_CONTROL_ADDR;
   assign wr_romh = reg_write_in.wr && reg_write_in.addr == ROM_DATA_HIGH_AND_WDT_CLEAR_ADDR;
   // Only a running core can issue halt; in halt the core clock is off
   assign halt_req = (mode_q == IHW_RUN) && halt_instr_in;
   // One nesting level: a second request waits until return_from_irq
   assign take_irq = (mode_q == IHW_RUN) && instr_done_in && global_irq_enable_q
                     && pwm_request_flag_q && !halt_instr_in;
   assign pwm_cycle_end = pwm_output_enable_q && (pwm_div_q == PWM_DIV_LAST);
   // Rising edge on any enabled pin, sampled from the second stage onward
   assign wake_event = (mode_q == IHW_HALT)
                       && |(sync2_q & ~sync3_q & wakeup_option_enable_in);
   assign wdt_clear = (wr_romh && wdt_option_enable_in) || halt_req
                      || (wake_event);
   assign wdt_overflow = wdt_option_enable_in && (wdt_q == WDT_LAST);

   // ----------------------------------------------------------------
   // Port wakeup synchroniser
   // ----------------------------------------------------------------
   // Two stages guard against metastability, third stage holds history
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync1_q <= '0;
         sync2_q <= '0;
         sync3_q <= '0;
      end else begin
         sync1_q <= port_a_pins_in;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   // ----------------------------------------------------------------
   // PWM cycle divider and request flag
   // ----------------------------------------------------------------
   // Divider runs only while PWM is enabled, so halting silences requests
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pwm_div_q <= COUNT_ZERO;
      end else if (!pwm_output_enable_q || pwm_cycle_end) begin
         pwm_div_q <= COUNT_ZERO;
      end else begin
         pwm_div_q <= pwm_div_q + COUNT_ONE;
      end
   end

   // Hardware set wins over a software clear in the same cycle
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pwm_request_flag_q <= 1'b0;
      end else if (chip_reset_req_in || wdt_overflow) begin
         pwm_request_flag_q <= 1'b0;
      end else if (pwm_cycle_end) begin
         pwm_request_flag_q <= 1'b1;
      end else if (wr_status) begin
         // Taking the interrupt never touches this flag
         pwm_request_flag_q <= reg_write_in.data[PWM_REQUEST_FLAG_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Control register and global enable
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         global_irq_enable_q <= PWM_CTRL_RESET[IRQ_ENABLE_FIELD_BIT];
         pwm_output_enable_q <= PWM_CTRL_RESET[PWM_OUTPUT_ENABLE_BIT];
      end else if (chip_reset_req_in || wdt_overflow) begin
         global_irq_enable_q <= 1'b0;
         pwm_output_enable_q <= 1'b0;
      end else if (take_irq) begin
         global_irq_enable_q <= 1'b0;
      end else if (return_from_irq_in && mode_q == IHW_RUN) begin
         global_irq_enable_q <= 1'b1;
      end else if (halt_req) begin
         pwm_output_enable_q <= 1'b0; // Halt disables the PWM
      end else if (wr_ctrl) begin
         global_irq_enable_q <= reg_write_in.data[IRQ_ENABLE_FIELD_BIT];
         pwm_output_enable_q <= reg_write_in.data[PWM_OUTPUT_ENABLE_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Context save and service tracking
   // ----------------------------------------------------------------
   // Hidden registers are loaded in the same clock the vector is taken
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         saved_q <= '0;
         in_service_q <= 1'b0;
      end else if (chip_reset_req_in || wdt_overflow) begin
         in_service_q <= 1'b0;
      end else if (take_irq) begin
         saved_q.pc <= next_pc_in;
         saved_q.page_data_high_pointer <= core_context_in.page_data_high_pointer;
         saved_q.memory_page_select <= core_context_in.memory_page_select;
         saved_q.carry_flag <= core_context_in.carry_flag;
         saved_q.zero_flag <= core_context_in.zero_flag;
         in_service_q <= 1'b1;
      end else if (return_from_irq_in && mode_q == IHW_RUN) begin
         in_service_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Mode sequencer: run, halt, stabilisation
   // ----------------------------------------------------------------
   // Reset has priority over wakeup in every mode
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode_q <= IHW_STABLE;
         stable_q <= COUNT_ZERO;
      end else if (chip_reset_req_in || wdt_overflow) begin
         mode_q <= IHW_STABLE;
         stable_q <= COUNT_ZERO;
      end else begin
         unique case (mode_q)
            IHW_RUN: begin
               if (halt_req) begin
                  mode_q <= IHW_HALT;
               end
            end
            IHW_HALT: begin
               // Register writes still land but do not change the mode here; only a wake edge leaves
               if (wake_event) begin
                  mode_q <= IHW_STABLE;
                  stable_q <= COUNT_ZERO;
               end
            end
            IHW_STABLE: begin
               if (stable_q == STABLE_LAST) begin
                  mode_q <= IHW_RUN;
               end else begin
                  stable_q <= stable_q + COUNT_ONE;
               end
            end
            default: begin
               mode_q <= IHW_STABLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Watchdog counter
   // ----------------------------------------------------------------
   // Frozen in halt since the core clock is stopped there
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wdt_q <= COUNT_ZERO;
         watchdog_reset_out <= 1'b0;
      end else begin
         watchdog_reset_out <= wdt_overflow;
         if (chip_reset_req_in || wdt_overflow || wdt_clear || !wdt_option_enable_in) begin
            wdt_q <= COUNT_ZERO;
         end else if (mode_q != IHW_HALT) begin
            wdt_q <= wdt_q + COUNT_ONE;
         end
      end
   end

   // ----------------------------------------------------------------
   // Data high nibble storage
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rom_data_high_q <= NIBBLE_ZERO;
      end else if (wr_romh) begin
         rom_data_high_q <= reg_write_in.data;
      end
   end

   // ----------------------------------------------------------------
   // Program counter load and restore outputs
   // ----------------------------------------------------------------
   // Vector loads are one-cycle pulses; the vector stays put between them
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pc_load_out <= 1'b1;
         pc_load_value_out <= RESET_VECTOR;
         restore_valid_out <= 1'b0;
         restore_context_out <= '0;
      end else begin
         pc_load_out <= 1'b0;
         restore_valid_out <= 1'b0;
         if (chip_reset_req_in || wdt_overflow) begin
            pc_load_out <= 1'b1;
            pc_load_value_out <= RESET_VECTOR;
         end else if (halt_req) begin
            pc_load_out <= 1'b1;
            pc_load_value_out <= WAKEUP_VECTOR;
         end else if (take_irq) begin
            pc_load_out <= 1'b1;
            pc_load_value_out <= IRQ_VECTOR;
         end else if (return_from_irq_in && mode_q == IHW_RUN && in_service_q) begin
            pc_load_out <= 1'b1;
            pc_load_value_out <= saved_q.pc;
            restore_valid_out <= 1'b1;
            restore_context_out <= saved_q;
         end
      end
   end

   // Core clock gate; SRAM keeps its contents because only the clock stops
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         core_clock_run_out <= 1'b0;
      end else begin
         core_clock_run_out <= (mode_q == IHW_RUN) && !halt_req
                               && !chip_reset_req_in && !wdt_overflow;
      end
   end

   // ----------------------------------------------------------------
   // Register readback
   // ----------------------------------------------------------------
   always_comb begin
      rd_d = NIBBLE_ZERO;
      unique case (reg_read_addr_in)
         FLAGS_AND_IRQ_STATUS_ADDR: begin
            rd_d[PWM_REQUEST_FLAG_BIT] = pwm_request_flag_q;
            rd_d[CARRY_FLAG_BIT] = core_context_in.carry_flag;
            rd_d[ZERO_FLAG_BIT] = core_context_in.zero_flag;
         end
         AUDIO_PWM_CONTROL_ADDR: begin
            rd_d[IRQ_ENABLE_FIELD_BIT] = global_irq_enable_q;
            rd_d[PWM_OUTPUT_ENABLE_BIT] = pwm_output_enable_q;
         end
         ROM_DATA_HIGH_AND_WDT_CLEAR_ADDR: begin
            rd_d = rom_data_high_q;
         end
         default: begin
            rd_d = NIBBLE_ZERO;
         end
      endcase
   end

   // Registered copies for the status outputs
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reg_read_data_out <= NIBBLE_ZERO;
         global_irq_enable_out <= 1'b0;
         pwm_output_enable_out <= 1'b0;
         pwm_request_flag_out <= 1'b0;
      end else begin
         reg_read_data_out <= rd_d;
         global_irq_enable_out <= global_irq_enable_q;
         pwm_output_enable_out <= pwm_output_enable_q;
         pwm_request_flag_out <= pwm_request_flag_q;
      end
   end
endmodule

`default_nettype wire

/* testbench/ihw_unit_asserts.sv */
// Port-level checks for the interrupt, halt and watchdog unit
`timescale 1ns/1ps
`default_nettype none
module ihw_unit_asserts
   import ihw_pkg::*;
#(
   parameter longint STABLE_COUNT = 20
) (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic chip_reset_req_in,
   input wire logic return_from_irq_in,
   input wire logic halt_instr_in,
   input wire logic wdt_option_enable_in,
   input wire logic pc_load_out,
   input wire logic [11:0] pc_load_value_out,
   input wire logic restore_valid_out,
   input wire logic core_clock_run_out,
   input wire logic global_irq_enable_out,
   input wire logic pwm_output_enable_out,
   input wire logic pwm_request_flag_out,
   input wire logic watchdog_reset_out
);
   int low_cnt_q;
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   // Length of the current clock stop; a short stop means a skipped delay
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         low_cnt_q <= 0;
      end else if (core_clock_run_out) begin
         low_cnt_q <= 0;
      end else begin
         low_cnt_q <= low_cnt_q + 1;
      end
   end
   // --------
   // Sequences
   // --------
   sequence s_load(logic [11:0] v);
      pc_load_out && pc_load_value_out == v;
   endsequence
   sequence s_entry;
      pc_load_out && !restore_valid_out && pc_load_value_out == IRQ_VECTOR;
   endsequence
   sequence s_halt_req;
      halt_instr_in && core_clock_run_out && !chip_reset_req_in;
   endsequence
   // --------
   // Assertions
   // --------
   a_irq_accept: assert property (
      s_entry |-> global_irq_enable_out && pwm_request_flag_out)
      else $error("interrupt entry without enable and request");
   a_irq_clears: assert property (
      s_entry |=> !global_irq_enable_out && pwm_request_flag_out)
      else $error("entry left enable set or dropped request");
   a_return_enable: assert property (
      return_from_irq_in && core_clock_run_out && !chip_reset_req_in |-> ##2 global_irq_enable_out)
      else $error("return did not set the global enable");
   a_halt_vector: assert property (
      s_halt_req |=> s_load(WAKEUP_VECTOR) ##0 !core_clock_run_out)
      else $error("halt did not load the wakeup vector and stop");
   a_halt_pwm: assert property (
      s_halt_req |-> ##2 !pwm_output_enable_out)
      else $error("halt left the audio output enabled");
   a_no_irq_halted: assert property (
      pc_load_out && !core_clock_run_out |-> pc_load_value_out != IRQ_VECTOR || restore_valid_out)
      else $error("interrupt taken with core clock stopped");
   a_chip_reset: assert property (
      $rose(chip_reset_req_in) |=> s_load(RESET_VECTOR) ##[0:1] !core_clock_run_out)
      else $error("chip reset did not load the reset vector");
   a_wdt_reset: assert property (
      watchdog_reset_out |-> ##[0:2] s_load(RESET_VECTOR))
      else $error("watchdog overflow did not restart the chip");
   a_wdt_pulse: assert property (
      watchdog_reset_out |=> !watchdog_reset_out)
      else $error("watchdog reset longer than one cycle");
   a_wdt_off: assert property (
      !wdt_option_enable_in && !$past(wdt_option_enable_in, 2) |-> !watchdog_reset_out)
      else $error("watchdog fired while disabled");
   a_stable_hold: assert property (
      $rose(core_clock_run_out) |-> low_cnt_q >= STABLE_COUNT - 1)
      else $error("core clock restarted before the stabilisation delay");
endmodule

bind ihw_unit ihw_unit_asserts #(.STABLE_COUNT(STABLE_COUNT)) i_ihw_unit_asserts (
   .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .chip_reset_req_in(chip_reset_req_in),
   .return_from_irq_in(return_from_irq_in), .halt_instr_in(halt_instr_in),
   .wdt_option_enable_in(wdt_option_enable_in), .pc_load_out(pc_load_out),
   .pc_load_value_out(pc_load_value_out), .restore_valid_out(restore_valid_out),
   .core_clock_run_out(core_clock_run_out), .global_irq_enable_out(global_irq_enable_out),
   .pwm_output_enable_out(pwm_output_enable_out), .pwm_request_flag_out(pwm_request_flag_out),
   .watchdog_reset_out(watchdog_reset_out)
);
`default_nettype wire

/* testbench/ihw_core_model.sv */
// Behavioural core: program counter that follows vector loads and instruction pacing
`timescale 1ns/1ps
`default_nettype none
module ihw_core_model (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic slow_in,
   input wire logic pc_load_in,
   input wire logic [11:0] pc_load_value_in,
   input wire logic clock_run_in,
   output logic [11:0] next_pc_out,
   output logic instr_done_out
);
   logic [11:0] pc_q;
   logic half_q;
   // Slow pacing ends an instruction only every other cycle
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         half_q <= 1'b0;
      end else begin
         half_q <= ~half_q;
      end
   end
   // Vector loads win; a stopped core clock freezes the count
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pc_q <= 12'h000;
      end else if (pc_load_in) begin
         pc_q <= pc_load_value_in;
      end else if (instr_done_out) begin
         pc_q <= next_pc_out;
      end
   end
   assign instr_done_out = clock_run_in && (!slow_in || half_q);
   assign next_pc_out = pc_q + 12'h001;
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the interrupt, halt and watchdog unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import ihw_pkg::*;
   localparam int STB = 20;
   localparam int WDT = 200;
   localparam int DIV = 16;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic chip_rst = 1'b0;
   logic ret = 1'b0;
   logic halt = 1'b0;
   logic slow = 1'b0;
   logic wdt_en = 1'b0;
   logic [3:0] wk_en = 4'h1;
   logic [3:0] pins = 4'h0;
   logic [4:0] rd_addr = 5'h00;
   ihw_context_type ctx = '{12'h000, 4'h0, 2'h0, 1'b1, 1'b0};
   ihw_reg_write_type rw = '0;
   ihw_context_type rctx;
   logic [11:0] next_pc, pc_val;
   logic [23:0] pc_d;
   logic [3:0] rdata;
   logic instr_done, pc_load, rvalid, run, gie, pwe, flag, wdog;
   int error_cnt = 0;
   int cmp_count = 0;
   int cyc = 0;
   // Short counts keep the run brief
   ihw_unit #(.STABLE_COUNT(STB), .WDT_COUNT(WDT), .IRQ_DIV(DIV)) i_ihw_unit (
      .ref_clk_in(clk), .rst_n_in(rst_n), .chip_reset_req_in(chip_rst), .next_pc_in(next_pc),
      .core_context_in(ctx), .instr_done_in(instr_done), .return_from_irq_in(ret),
      .halt_instr_in(halt), .reg_write_in(rw), .reg_read_addr_in(rd_addr),
      .wdt_option_enable_in(wdt_en), .wakeup_option_enable_in(wk_en), .port_a_pins_in(pins),
      .pc_load_out(pc_load), .pc_load_value_out(pc_val), .restore_context_out(rctx),
      .restore_valid_out(rvalid), .core_clock_run_out(run), .reg_read_data_out(rdata),
      .global_irq_enable_out(gie), .pwm_output_enable_out(pwe),
      .pwm_request_flag_out(flag), .watchdog_reset_out(wdog));
   ihw_core_model i_ihw_core_model (.clk_in(clk), .rst_n_in(rst_n), .slow_in(slow),
      .pc_load_in(pc_load), .pc_load_value_in(pc_val), .clock_run_in(run),
      .next_pc_out(next_pc), .instr_done_out(instr_done));
   // --------
   // Clock, history and helpers
   // --------
   always #20 clk = ~clk;
   // Two edges of history recover the next-pc sampled at the take edge
   always @(posedge clk) pc_d <= {pc_d[11:0], next_pc};
   always @(negedge clk) cyc <= cyc + 1;
   task automatic tally_and_finish;
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   // The strobe drops for one edge so back-to-back writes stay distinct
   task automatic wr(input logic [4:0] a, input logic [3:0] d);
      rw = '{1'b1, a, d};
      tick(1);
      rw.wr = 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [4:0] a, output logic [3:0] d);
      rd_addr = a;
      tick(2);
      d = rdata;
   endtask
   function automatic bit hit(input int w);
      case (w)
         0: return run === 1'b1;
         1: return pc_load === 1'b1 && pc_val === IRQ_VECTOR && rvalid === 1'b0;
         2: return flag === 1'b1;
         default: return wdog === 1'b1;
      endcase
   endfunction
   // Bounded wait; n equals lim when the event never came
   task automatic wait_for(input int w, input int lim, output int n);
      n = 0;
      while (!hit(w) && n < lim) begin
         tick(1);
         n++;
      end
   endtask
   // --------
   // Scenarios
   // --------
   task automatic t_reset;
      int n;
      logic [3:0] d;
      tick(2);
      rst_n = 1'b1;
      wait_for(0, STB + 12, n);
      chk(n >= STB - 1 && n <= STB + 3, 1'b1);
      rd(FLAGS_AND_IRQ_STATUS_ADDR, d);
      chk(d, 4'h2);
      rd(AUDIO_PWM_CONTROL_ADDR, d);
      chk(d[1:0], 2'h0);
      rd(5'h17, d);
      chk(d, 4'h0);
   endtask
   // Slow core; entry, no nesting, return with context, then the request period
   task automatic t_irq;
      int n, t0, t1;
      logic [11:0] saved;
      slow = 1'b1;
      ctx = '{12'h000, 4'hA, 2'h2, 1'b1, 1'b0};
      wr(AUDIO_PWM_CONTROL_ADDR, 4'h3);
      wait_for(1, 2 * DIV + 8, n);
      chk(n < 2 * DIV + 8, 1'b1);
      saved = pc_d[23:12];
      tick(1);
      chk({gie, flag}, 2'b01);
      wait_for(1, 3 * DIV, n);
      chk(n, 3 * DIV);
      ctx = '{12'h000, 4'h5, 2'h1, 1'b0, 1'b1};
      wr(FLAGS_AND_IRQ_STATUS_ADDR, 4'h0);
      ret = 1'b1;
      tick(1);
      ret = 1'b0;
      chk({rvalid, pc_load, pc_val}, {2'b11, saved});
      chk(rctx[7:0], 8'hAA);
      chk(rctx.pc, saved);
      tick(1);
      chk(gie, 1'b1);
      wr(AUDIO_PWM_CONTROL_ADDR, 4'h1);
      // Third round is timed; the first may land on a set edge
      for (int i = 0; i < 3; i++) begin
         t0 = t1;
         wr(FLAGS_AND_IRQ_STATUS_ADDR, 4'h0);
         wait_for(2, DIV + 4, n);
         t1 = cyc;
      end
      chk(t1 - t0, DIV);
      slow = 1'b0;
   endtask
   task automatic t_halt;
      int n;
      wdt_en = 1'b1;
      wr(ROM_DATA_HIGH_AND_WDT_CLEAR_ADDR, 4'h0);
      tick(WDT - 50);
      halt = 1'b1;
      tick(1);
      halt = 1'b0;
      chk({pc_load, pc_val, run}, {1'b1, WAKEUP_VECTOR, 1'b0});
      tick(1);
      chk(pwe, 1'b0);
      wr(AUDIO_PWM_CONTROL_ADDR, 4'h3);
      pins = 4'h2;
      wait_for(3, WDT + 50, n);
      chk({run, n[14:0]}, WDT + 50);
      pins = 4'h3;
      wait_for(0, STB + 12, n);
      chk(n >= STB && n <= STB + 8, 1'b1);
      wait_for(3, WDT - 60, n);
      chk(n, WDT - 60);
      pins = 4'h0;
   endtask
   task automatic t_wdt;
      int n;
      logic [3:0] d;
      for (int i = 0; i < 3; i++) begin
         wr(ROM_DATA_HIGH_AND_WDT_CLEAR_ADDR, 4'h0);
         wait_for(3, WDT - 40, n);
         chk(n, WDT - 40);
      end
      wr(ROM_DATA_HIGH_AND_WDT_CLEAR_ADDR, 4'h0);
      wait_for(3, WDT + 10, n);
      chk(n >= WDT - 4 && n <= WDT + 2, 1'b1);
      tick(2);
      chk(run, 1'b0);
      wdt_en = 1'b0;
      wait_for(0, STB + 12, n);
      chk(n >= STB - 3 && n <= STB + 1, 1'b1);
      // With the option off the write only stores the nibble
      wr(ROM_DATA_HIGH_AND_WDT_CLEAR_ADDR, 4'h9);
      rd(ROM_DATA_HIGH_AND_WDT_CLEAR_ADDR, d);
      chk(d, 4'h9);
      wait_for(3, WDT + 20, n);
      chk(n, WDT + 20);
   endtask
   task automatic t_chip;
      int n;
      halt = 1'b1;
      tick(1);
      halt = 1'b0;
      tick(5);
      chip_rst = 1'b1;
      tick(1);
      chip_rst = 1'b0;
      chk({pc_load, pc_val}, {1'b1, RESET_VECTOR});
      wait_for(0, STB + 12, n);
      chk(n >= STB - 1 && n <= STB + 3, 1'b1);
   endtask
   initial begin
      t_reset();
      t_irq();
      t_halt();
      t_wdt();
      t_chip();
      tally_and_finish();
   end
   // A hang costs one mismatch and ends the run through the same verdict
   initial begin
      repeat (6000) @(negedge clk);
      error_cnt++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
